/* dv/lpm_chk_checker.sv */
`timescale 1ns/100ps
module lpm_chk
	import lpm_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire lpm_cmd_t   cmd,
	input wire lpm_wake_t  wake_in,
	input wire lpm_gate_t  gate,
	input wire lpm_state_t mode
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence halt_quiet;
		(mode == LPM_HALT && !wake_in.irq_ext && !wake_in.wkup_per) [*4];
	endsequence
	sequence lpwait_evt;
		mode == LPM_LPWAIT && $rose(|wake_in.evt);
	endsequence
	a_wait_gate: assert property (mode == LPM_WAIT |-> !gate.cpu_clk_en)
		else $error("cpu clock on in wait");
	a_wait_entry: assert property (mode == LPM_RUN && (cmd.wait_for_interrupt_instruction || cmd.wait_for_event_instruction) && !cmd.halt && !cmd.lprun_enter
		|=> mode == LPM_WAIT) else $error("no wait entry");
	a_lprun_cfg: assert property (mode == LPM_LPRUN |-> gate.cpu_clk_en && gate.ram_exec && !gate.flash_en
		&& !gate.eeprom_en && gate.low_power_regulator_mode) else $error("bad low power run gating");
	a_lprun_hold: assert property (mode == LPM_LPRUN && !cmd.wait_for_event_instruction && !cmd.lprun_exit |=> mode == LPM_LPRUN)
		else $error("low power run left");
	a_lpwait_entry: assert property (mode == LPM_LPRUN && cmd.wait_for_event_instruction && !cmd.lprun_exit
		|=> mode == LPM_LPWAIT && !gate.cpu_clk_en) else $error("no low power wait entry");
	a_lpwait_exit: assert property (lpwait_evt |-> ##[1:4] mode == LPM_LPRUN)
		else $error("event did not resume low power run");
	a_halt_cfg: assert property (mode inside {LPM_AHALT, LPM_HALT} |-> !gate.cpu_clk_en
		&& gate.low_power_regulator_mode && gate.core_pwr_on) else $error("bad halt gating");
	a_halt_hold: assert property (halt_quiet |=> mode == LPM_HALT)
		else $error("halt left without wakeup");
	a_reset_run: assert property ($rose(nrst) |-> mode == LPM_RUN && gate.per_clk_en == PER_CLK_RST)
		else $error("not in run after reset");
endmodule
bind lpm_ctrl lpm_chk i_lpm_chk (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd), .wake_in(wake_in), .gate(gate),
	.mode(mode));

/* dv/lpm_cpu_model.sv */
`timescale 1ns/100ps
module lpm_cpu_model
	import lpm_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic [2:0] op,
	input  wire logic       go,
	output lpm_cmd_t        cmd
);
	// One-cycle instruction pulse: 0 wfi, 1 wfe, 2 halt, 3 enter, 4 exit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			cmd <= '0;
		else
			cmd <= go ? lpm_cmd_t'(5'h10 >> op) : '0;
	end
endmodule

/* dv/tb.sv */
`timescale 1ns/100ps
module tb;
	import lpm_pkg::*;
	logic       sys_clk = 0, nrst = 0, go = 0, vref_off_halt = 0, fast_wake = 0, rtc_in_halt = 0, osc_sel_ext = 0;
	logic [2:0] op = 0;
	logic [7:0] wait_per_sel = 0;
	logic [31:0] rng = 34;
	lpm_wake_t  wake_in = '0;
	lpm_cmd_t   cmd;
	lpm_gate_t  gate;
	lpm_state_t mode;
	logic       osc_ext_sel, wake_busy;
	int         failures = 0, checks = 0, cyc = 0, n, e;
	always #2 sys_clk = ~sys_clk;
	lpm_cpu_model i_lpm_cpu_model (.sys_clk(sys_clk), .nrst(nrst), .op(op), .go(go), .cmd(cmd));
	lpm_ctrl #(.FAST_CYC(4), .SLOW_CYC(10)) i_lpm_ctrl (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd),
		.wake_in(wake_in), .wait_per_sel(wait_per_sel), .vref_off_halt(vref_off_halt), .fast_wake(fast_wake),
		.rtc_in_halt(rtc_in_halt), .osc_sel_ext(osc_sel_ext), .gate(gate), .mode(mode),
		.osc_ext_sel(osc_ext_sel), .wake_busy(wake_busy));
	function automatic logic [31:0] xorshift(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic rnd();
		rng = xorshift(rng);
	endtask
	task automatic complete_run();
		$display("failures %0d checks %0d", failures, checks);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp_mode(lpm_state_t x);
		checks++;
		if (mode !== x) begin
			failures++;
			$display("wrong value at %0t: %h vs %h", $time, mode, x);
		end
	endtask
	task automatic cmp_bits(logic [7:0] g, logic [7:0] x);
		checks++;
		if (g !== x) begin
			failures++;
			$display("wrong value at %0t: %h vs %h", $time, g, x);
		end
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic issue(logic [2:0] o);
		op = o;
		go = 1;
		tick(1);
		go = 0;
		tick(2);
	endtask
	task automatic wait_mode(lpm_state_t x);
		n = 0;
		while (mode !== x && n < 40) begin
			tick(1);
			n++;
		end
		cmp_mode(x);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		tick(20);
		nrst = 1;
		tick(1);
		cmp_bits(gate.per_clk_en, PER_CLK_RST);
		for (int i = 0; i < 2; i++) begin
			rnd();
			wait_per_sel = rng[7:0];
			issue(3'(i));
			cmp_mode(LPM_WAIT);
			cmp_bits({7'h0, gate.cpu_clk_en}, 8'h00);
			cmp_bits(gate.per_clk_en, wait_per_sel);
			wake_in.irq_int = i[0];
			wake_in.irq_ext = !i[0];
			wait_mode(LPM_RUN);
			wake_in = '0;
			tick(2);
		end
		rnd();
		osc_sel_ext = rng[0];
		issue(3);
		cmp_mode(LPM_LPRUN);
		cmp_bits({gate.per_clk_en[7:1], osc_ext_sel}, {7'h01, osc_sel_ext});
		wake_in.irq_int = 1;
		wake_in.irq_ext = 1;
		tick(6);
		cmp_mode(LPM_LPRUN);
		issue(1);
		tick(6);
		cmp_mode(LPM_LPWAIT);
		wake_in.evt = 5'h01 << (rng[7:0] % 5);
		wait_mode(LPM_LPRUN);
		wake_in = '0;
		tick(3);
		issue(4);
		cmp_mode(LPM_RUN);
		for (int i = 0; i < 3; i++) begin
			rtc_in_halt = (i == 2);
			vref_off_halt = (i != 0);
			fast_wake = (i == 2);
			issue(2);
			cmp_bits({gate.core_pwr_on, gate.rtc_clk_en, gate.vref_on},
				{1'b1, rtc_in_halt, !(vref_off_halt && !rtc_in_halt)});
			wake_in.irq_int = 1;
			wake_in.irq_rtc = !rtc_in_halt;
			tick(6);
			cmp_mode(rtc_in_halt ? LPM_AHALT : LPM_HALT);
			wake_in.irq_rtc = rtc_in_halt;
			wake_in.irq_ext = (i == 1);
			wake_in.wkup_per = (i == 0);
			wait_mode(LPM_WAKE);
			e = (vref_off_halt && !fast_wake) ? 10 : 4;
			n = 0;
			while (wake_busy === 1'b1 && n < 40) begin
				tick(1);
				n++;
			end
			cmp_bits(8'(n), 8'(e));
			cmp_mode(LPM_RUN);
			wake_in = '0;
			tick(3);
		end
		issue(3);
		nrst = 0;
		tick(1);
		nrst = 1;
		tick(1);
		cmp_mode(LPM_RUN);
		complete_run();
	end
endmodule

/* src/lpm_ctrl.sv */
`timescale 1ns/100ps
module lpm_ctrl
	import lpm_pkg::*;
#(
	parameter int                FAST_CYC = FAST_WAKE_CYC,
	parameter int                SLOW_CYC = VREF_WAKE_CYC,
	parameter logic [NPER-1:0]   KEEP_ONE = 8'h02
) (
	input  wire logic            sys_clk,
	input  wire logic            nrst,
	input  wire lpm_cmd_t        cmd,
	input  wire lpm_wake_t       wake_in,
	input  wire logic [NPER-1:0] wait_per_sel,
	input  wire logic            vref_off_halt,
	input  wire logic            fast_wake,
	input  wire logic            rtc_in_halt,
	input  wire logic            osc_sel_ext,
	output lpm_gate_t            gate,
	output lpm_state_t           mode,
	output logic                 osc_ext_sel,
	output logic                 wake_busy
);

	typedef struct packed {
		lpm_state_t       st;
		lpm_gate_t        g;
		logic             ext;
		logic [WCNT_W-1:0] cnt;
		logic             busy;
	} lpm_ctrl_st_t;

	lpm_ctrl_st_t st_q;
	lpm_ctrl_st_t st_d;
	lpm_wake_t    wk;

	// Wakeup sources come from other domains and pins
	lpm_sync #(
		.W($bits(lpm_wake_t))
	) u_sync (
		.sys_clk(sys_clk),
		.nrst   (nrst),
		.din    (wake_in),
		.dout   (wk)
	);

	function automatic lpm_gate_t gates_for(input lpm_state_t s, input logic [NPER-1:0] sel,
			input logic vr_off, input logic rtc_on, input logic ext);
		lpm_gate_t g;
		g                          = '0;
		g.core_pwr_on              = 1'b1;
		g.vref_on                  = 1'b1;
		case (s)
			LPM_RUN, LPM_WAKE: begin
				g.cpu_clk_en = 1'b1;
				g.per_clk_en = PER_CLK_RST;
				g.rtc_clk_en = 1'b1;
				g.flash_en   = 1'b1;
				g.eeprom_en  = 1'b1;
			end
			LPM_WAIT: begin
				g.per_clk_en = sel;
				g.rtc_clk_en = 1'b1;
				g.flash_en   = 1'b1;
				g.eeprom_en  = 1'b1;
			end
			LPM_LPRUN, LPM_LPWAIT: begin
				g.cpu_clk_en               = (s == LPM_LPRUN);
				g.per_clk_en               = KEEP_ONE;
				g.rtc_clk_en               = 1'b1;
				g.ram_exec                 = 1'b1;
				g.low_speed_sel            = 1'b1;
				g.low_power_regulator_mode = 1'b1;
			end
			LPM_AHALT: begin
				g.rtc_clk_en               = 1'b1;
				g.low_power_regulator_mode = 1'b1;
			end
			LPM_HALT: begin
				g.rtc_clk_en               = rtc_on;
				g.vref_on                  = !vr_off;
				g.low_power_regulator_mode = 1'b1;
			end
			default: begin
				g.cpu_clk_en = 1'b1;
			end
		endcase
		return g;
	endfunction

	always_comb begin
		st_d      = st_q;
		st_d.busy = 1'b0;
		case (st_q.st)
			LPM_RUN: begin
				if (cmd.lprun_enter) begin
					st_d.st  = LPM_LPRUN;
					st_d.ext = osc_sel_ext;
				end else if (cmd.halt) begin
					st_d.st = rtc_in_halt ? LPM_AHALT : LPM_HALT;
				end else if (cmd.wait_for_interrupt_instruction || cmd.wait_for_event_instruction) begin
					st_d.st = LPM_WAIT;
				end
			end
			LPM_WAIT: begin
				if (wk.irq_int || wk.irq_ext || wk.irq_rtc) begin
					st_d.st = LPM_RUN;
				end
			end
			LPM_LPRUN: begin
				if (cmd.lprun_exit) begin
					st_d.st = LPM_RUN;
				end else if (cmd.wait_for_event_instruction) begin
					st_d.st = LPM_LPWAIT;
				end
			end
			LPM_LPWAIT: begin
				// Interrupts are ignored here, only events wake
				if (|wk.evt) begin
					st_d.st = LPM_LPRUN;
				end
			end
			LPM_AHALT: begin
				if (wk.irq_rtc || wk.irq_ext) begin
					st_d.st   = LPM_WAKE;
					st_d.cnt  = WCNT_W'(FAST_CYC);
				end
			end
			LPM_HALT: begin
				if (wk.irq_ext || wk.wkup_per) begin
					st_d.st  = LPM_WAKE;
					st_d.cnt = (vref_off_halt && !fast_wake) ? WCNT_W'(SLOW_CYC)
					                                        : WCNT_W'(FAST_CYC);
				end
			end
			LPM_WAKE: begin
				st_d.busy = 1'b1;
				if (st_q.cnt <= WCNT_W'(1)) begin
					st_d.st   = LPM_RUN;
					st_d.busy = 1'b0;
				end else begin
					st_d.cnt = st_q.cnt - WCNT_W'(1);
				end
			end
			default: begin
				st_d.st = LPM_RUN;
			end
		endcase
		st_d.g = gates_for(st_d.st, wait_per_sel, vref_off_halt, rtc_in_halt, st_d.ext);
		// Busy flags the whole settling wait, in step with the mode output
		st_d.busy = (st_d.st == LPM_WAKE);
		if (st_d.st == LPM_WAKE) begin
			st_d.g.cpu_clk_en = 1'b0;
			st_d.g.vref_on    = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q.st   <= LPM_RUN;
			st_q.g    <= '{cpu_clk_en: 1'b1, per_clk_en: PER_CLK_RST, rtc_clk_en: 1'b1,
			              flash_en: 1'b1, eeprom_en: 1'b1, ram_exec: 1'b0, low_speed_sel: 1'b0,
			              low_power_regulator_mode: 1'b0, vref_on: 1'b1, core_pwr_on: 1'b1};
			st_q.ext  <= 1'b0;
			st_q.cnt  <= '0;
			st_q.busy <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign gate        = st_q.g;
	assign mode        = st_q.st;
	assign osc_ext_sel = st_q.ext;
	assign wake_busy   = st_q.busy;

endmodule

/* src/lpm_pkg.sv */
package lpm_pkg;

	localparam int NPER = 8;

	typedef enum logic [2:0] {
		LPM_RUN,
		LPM_WAIT,
		LPM_LPRUN,
		LPM_LPWAIT,
		LPM_AHALT,
		LPM_HALT,
		LPM_WAKE
	} lpm_state_t;

	typedef struct packed {
		logic wait_for_interrupt_instruction;
		logic wait_for_event_instruction;
		logic halt;
		logic lprun_enter;
		logic lprun_exit;
	} lpm_cmd_t;

	typedef struct packed {
		logic            irq_int;
		logic            irq_ext;
		logic            irq_rtc;
		logic            wkup_per;
		logic [4:0]      evt;
	} lpm_wake_t;

	typedef struct packed {
		logic            cpu_clk_en;
		logic [NPER-1:0] per_clk_en;
		logic            rtc_clk_en;
		logic            flash_en;
		logic            eeprom_en;
		logic            ram_exec;
		logic            low_speed_sel;
		logic            low_power_regulator_mode;
		logic            vref_on;
		logic            core_pwr_on;
	} lpm_gate_t;

	localparam logic [NPER-1:0] PER_CLK_RST = 8'hFF;
	localparam logic [2:0]      RTC_IDX     = 3'h0;
	localparam int              CLK_MHZ     = 250;
	localparam int              FAST_WAKE_NS = 6000;
	localparam int              FAST_WAKE_CYC = FAST_WAKE_NS * CLK_MHZ / 1000;
	localparam int              VREF_WAKE_NS  = 50000;
	localparam int              VREF_WAKE_CYC = VREF_WAKE_NS * CLK_MHZ / 1000;
	localparam int              WCNT_W        = 16;

endpackage

/* src/lpm_sync.sv */
`timescale 1ns/100ps
module lpm_sync
	import lpm_pkg::*;
#(
	parameter int W = 9
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lpm_sync_st_t;

	lpm_sync_st_t st_q;
	lpm_sync_st_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.s2;

endmodule
